// *** hdl/nidfc_pkg.sv ***
/*
 * Shared constants for the NAND identify and feature block: command
 * codes, feature addresses, field masks, reset values and busy times.
 * Assumes the reference clock runs at CLK_MHZ.
 */
package nidfc_pkg;

	localparam logic [7:0] CMD_READ_ID    = 8'h90;
	localparam logic [7:0] CMD_SET_FEAT   = 8'hef;
	localparam logic [7:0] CMD_GET_FEAT   = 8'hee;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_READ_MODE  = 8'h00;
	localparam logic [7:0] CMD_RESET      = 8'hff;
	localparam logic [7:0] CMD_SYNC_RESET = 8'hfc;

	localparam logic [7:0] ID_ADDR_CODE = 8'h00;
	localparam logic [7:0] ID_ADDR_SIG  = 8'h20;

	localparam logic [7:0] FA_TIMING    = 8'h01;
	localparam logic [7:0] FA_DRIVE     = 8'h10;
	localparam logic [7:0] FA_DRIVE_ALT = 8'h80;
	localparam logic [7:0] FA_RB_PULL   = 8'h81;
	localparam logic [7:0] FA_ARRAY     = 8'h90;

	localparam logic [7:0] TIMING_MASK = 8'h3f;
	localparam logic [7:0] DRIVE_MASK  = 8'h03;
	localparam logic [7:0] RB_MASK     = 8'h03;
	localparam logic [7:0] ARRAY_MASK  = 8'h01;

	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [7:0] DRIVE_RST  = 8'h02;
	localparam logic [7:0] RB_RST     = 8'h00;
	localparam logic [7:0] ARRAY_RST  = 8'h00;

	localparam int IFACE_BIT     = 4;
	localparam int IFACE_RSV_BIT = 5;

	localparam logic [7:0] STAT_READY = 8'h60;

	localparam logic [2:0] ID_BYTES    = 3'h5;
	localparam logic [2:0] SIG_BYTES   = 3'h4;
	localparam logic [2:0] PARAM_BYTES = 3'h4;
	localparam logic [2:0] STAT_BYTES  = 3'h1;
	localparam logic [1:0] LAST_PARAM  = 2'h3;

	localparam int CLK_MHZ  = 200;
	localparam int FEAT_NS  = 1000;
	localparam int ITC_NS   = 1000;
	localparam int FEAT_CYC = (FEAT_NS * CLK_MHZ + 999) / 1000;
	localparam int ITC_CYC  = (ITC_NS * CLK_MHZ + 999) / 1000;

	localparam logic [1:0] EV_CMD  = 2'h0;
	localparam logic [1:0] EV_ADDR = 2'h1;
	localparam logic [1:0] EV_DIN  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ID_ADDR,
		ST_SF_ADDR,
		ST_SF_DATA,
		ST_GF_ADDR
	} nidfc_state_t;

endpackage : nidfc_pkg

// *** hdl/nidfc_sync2.sv ***
/*
 * Two flip-flop level synchroniser, W bits wide.
 * Assumes each bit is a level that holds for several destination clocks.
 */
module nidfc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : nidfc_sync2

// *** hdl/nidfc_xfer.sv ***
/*
 * Toggle handshake carrying one 10-bit word per event between clocks.
 * Assumes the source sends only while src_busy is low; a send while
 * busy is dropped.
 */
module nidfc_xfer (
	input  wire logic       src_clk,
	input  wire logic       dst_clk,
	input  wire logic       rst,
	input  wire logic       send,
	input  wire logic [9:0] src_word,
	output logic            src_busy,
	output logic            dst_pulse,
	output logic      [9:0] dst_word
);

	logic req;
	logic ack_m;
	logic ack_s;
	logic req_m;
	logic req_s;
	logic req_q;

	assign src_busy  = req ^ ack_s;
	assign dst_pulse = req_s ^ req_q;

	always_ff @(posedge src_clk or posedge rst) begin
		if (rst) begin
			req      <= 1'b0;
			dst_word <= 10'h000;
			ack_m    <= 1'b0;
			ack_s    <= 1'b0;
		end else begin
			ack_m <= req_q;
			ack_s <= ack_m;
			if (send && !src_busy) begin
				req      <= ~req;
				dst_word <= src_word;
			end
		end
	end

	always_ff @(posedge dst_clk or posedge rst) begin
		if (rst) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			req_q <= 1'b0;
		end else begin
			req_m <= req;
			req_s <= req_m;
			req_q <= req_s;
		end
	end

endmodule : nidfc_xfer

// *** hdl/nidfc_top.sv ***
/*
 * NAND target command handling for identifier read, set features and
 * get features, with the feature store and the busy timer.
 * Assumes the host clocks the bus pins with link_clk and spaces bus
 * cycles so each event crosses before the next one.
 */
// How it works
// - ID and feature commands are taken only while the target is idle.
// - Command 90h enters identifier mode until another valid command.
// - Address 00h after 90h returns the five-byte identifier code.
// - Address 20h after 90h returns the four-byte signature instead.
// - ID bytes: one per read strobe; in DDR each byte repeats on falling edge.
// - Feature commands carry one address byte and four parameter bytes.
// - Feature values survive reset commands unless a feature says otherwise.
// - Addresses 01h, 10h, 80h, 81h, 90h are decoded; all others reserved.
// - Command EFh enters feature-write mode until another command other than 70h or 00h.
// - Each write strobe or DQS rise latches one parameter byte.
// - After the fourth parameter the target is busy for the feature time.
// - An interface change holds busy for the interface-change time.
// - Command EEh enters feature-read mode until another valid command.
// - Feature read goes busy; status read needs 00h to resume output.
// - Feature bytes: one per read strobe, or one per DQS edge in DDR.
// - Timing P1: bits 3:0 mode, 5:4 interface, rest zero, default zero.
// - FFh under DDR returns timing and interface bits to default.
// - FFh under asynchronous interface leaves timing bits unchanged.
module nidfc_top #(
	// Arbitrary identification values
	parameter logic [39:0] ID_CODE  = 40'h5544332211,
	parameter logic [31:0] SIG_CODE = 32'h7766aa99
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       link_clk,
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic [7:0] dq_i,
	output logic      [7:0] dq_o,
	output logic            dq_oe,
	input  wire logic       dqs_i,
	output logic            dqs_o,
	output logic            dqs_oe,
	output logic            rb_n_o,
	output logic            rb_n_oe
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	nidfc_pkg::nidfc_state_t state;

	logic [7:0]  feat_timing;
	logic [7:0]  feat_drive;
	logic [7:0]  feat_drive_alt;
	logic [7:0]  feat_rb;
	logic [7:0]  feat_array;
	logic [7:0]  fa;
	logic [1:0]  pcnt;
	logic [7:0]  p1_buf;
	logic [15:0] busy_cnt;
	logic        gf_pend;
	logic [39:0] out_data;
	logic [2:0]  out_len;
	logic        out_valid;
	logic        out_dup;
	logic        stat_mode;
	logic [39:0] pres_data;
	logic [2:0]  pres_len;
	logic        pres_valid;
	logic        pres_dup;

	logic        ev_pulse;
	logic [9:0]  ev_word;

	////////////////////////////////////////////////////////////////////
	// Event decode on the reference clock

	wire [1:0] ev_kind  = ev_word[9:8];
	wire [7:0] ev_byte  = ev_word[7:0];
	wire       ev_cmd   = ev_pulse && (ev_kind == nidfc_pkg::EV_CMD);
	wire       ev_addr  = ev_pulse && (ev_kind == nidfc_pkg::EV_ADDR);
	wire       ev_din   = ev_pulse && (ev_kind == nidfc_pkg::EV_DIN);
	wire       idle     = (busy_cnt == 16'h0000);
	wire       sync_on  = feat_timing[nidfc_pkg::IFACE_BIT];

	wire is_reset  = ev_cmd && (ev_byte == nidfc_pkg::CMD_RESET);
	wire is_sreset = ev_cmd && (ev_byte == nidfc_pkg::CMD_SYNC_RESET) && sync_on;
	wire do_reset  = is_reset || is_sreset;
	wire is_status = ev_cmd && (ev_byte == nidfc_pkg::CMD_STATUS);
	wire is_rmode  = ev_cmd && (ev_byte == nidfc_pkg::CMD_READ_MODE);

	wire accept    = ev_cmd && idle && !do_reset && !is_status && !is_rmode;
	wire start_id  = accept && (ev_byte == nidfc_pkg::CMD_READ_ID);
	wire start_sf  = accept && (ev_byte == nidfc_pkg::CMD_SET_FEAT);
	wire start_gf  = accept && (ev_byte == nidfc_pkg::CMD_GET_FEAT);

	wire id_addr   = (state == nidfc_pkg::ST_ID_ADDR) && ev_addr;
	wire sf_addr   = (state == nidfc_pkg::ST_SF_ADDR) && ev_addr;
	wire sf_din    = (state == nidfc_pkg::ST_SF_DATA) && ev_din;
	wire sf_last   = sf_din && (pcnt == nidfc_pkg::LAST_PARAM);
	wire gf_addr   = (state == nidfc_pkg::ST_GF_ADDR) && ev_addr;

	wire fa_tim    = (fa == nidfc_pkg::FA_TIMING);
	wire fa_drv    = (fa == nidfc_pkg::FA_DRIVE);
	wire fa_drva   = (fa == nidfc_pkg::FA_DRIVE_ALT);
	wire fa_rb     = (fa == nidfc_pkg::FA_RB_PULL);
	wire fa_arr    = (fa == nidfc_pkg::FA_ARRAY);

	wire [7:0] feat_rd = fa_tim  ? feat_timing :
	                     fa_drv  ? feat_drive :
	                     fa_drva ? feat_drive_alt :
	                     fa_rb   ? feat_rb :
	                     fa_arr  ? feat_array : 8'h00;

	// A reserved interface code is refused rather than stored
	wire tim_rsv   = p1_buf[nidfc_pkg::IFACE_RSV_BIT];
	wire wr_tim    = sf_last && fa_tim && !tim_rsv;
	wire iface_chg = wr_tim &&
	                 (p1_buf[nidfc_pkg::IFACE_BIT] != feat_timing[nidfc_pkg::IFACE_BIT]);

	wire [7:0] stat_byte = idle ? nidfc_pkg::STAT_READY : 8'h00;

	////////////////////////////////////////////////////////////////////
	// Command state

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= nidfc_pkg::ST_IDLE;
		end else if (do_reset || accept) begin
			if (start_id) begin
				state <= nidfc_pkg::ST_ID_ADDR;
			end else if (start_sf) begin
				state <= nidfc_pkg::ST_SF_ADDR;
			end else if (start_gf) begin
				state <= nidfc_pkg::ST_GF_ADDR;
			end else begin
				state <= nidfc_pkg::ST_IDLE;
			end
		end else begin
			case (state)
				nidfc_pkg::ST_ID_ADDR: begin
					if (ev_addr) state <= nidfc_pkg::ST_IDLE;
				end
				nidfc_pkg::ST_SF_ADDR: begin
					if (ev_addr) state <= nidfc_pkg::ST_SF_DATA;
				end
				nidfc_pkg::ST_SF_DATA: begin
					if (sf_last) state <= nidfc_pkg::ST_IDLE;
				end
				nidfc_pkg::ST_GF_ADDR: begin
					if (ev_addr) state <= nidfc_pkg::ST_IDLE;
				end
				default: begin
					state <= nidfc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fa     <= 8'h00;
			pcnt   <= 2'h0;
			p1_buf <= 8'h00;
		end else begin
			if (sf_addr || gf_addr) begin
				fa   <= ev_byte;
				pcnt <= 2'h0;
			end
			if (sf_din) begin
				pcnt <= pcnt + 2'h1;
				if (pcnt == 2'h0) p1_buf <= ev_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Feature store

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			feat_timing    <= nidfc_pkg::TIMING_RST;
			feat_drive     <= nidfc_pkg::DRIVE_RST;
			feat_drive_alt <= nidfc_pkg::DRIVE_RST;
			feat_rb        <= nidfc_pkg::RB_RST;
			feat_array     <= nidfc_pkg::ARRAY_RST;
		end else if (do_reset) begin
			if (is_reset && sync_on) feat_timing <= nidfc_pkg::TIMING_RST;
			if (is_reset) feat_array <= nidfc_pkg::ARRAY_RST;
		end else if (sf_last) begin
			if (wr_tim) feat_timing <= p1_buf & nidfc_pkg::TIMING_MASK;
			if (fa_drv) feat_drive <= p1_buf & nidfc_pkg::DRIVE_MASK;
			if (fa_drva) feat_drive_alt <= p1_buf & nidfc_pkg::DRIVE_MASK;
			if (fa_rb) feat_rb <= p1_buf & nidfc_pkg::RB_MASK;
			if (fa_arr) feat_array <= p1_buf & nidfc_pkg::ARRAY_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Busy timer

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_cnt <= 16'h0000;
			gf_pend  <= 1'b0;
		end else if (do_reset) begin
			busy_cnt <= 16'h0000;
			gf_pend  <= 1'b0;
		end else if (sf_last) begin
			busy_cnt <= iface_chg ? 16'(nidfc_pkg::ITC_CYC) : 16'(nidfc_pkg::FEAT_CYC);
		end else if (gf_addr) begin
			busy_cnt <= 16'(nidfc_pkg::FEAT_CYC);
			gf_pend  <= 1'b1;
		end else if (!idle) begin
			busy_cnt <= busy_cnt - 16'h0001;
			if (busy_cnt == 16'h0001) gf_pend <= 1'b0;
		end
	end

	// Busy pulls the open-drain ready line low
	assign rb_n_o  = 1'b0;
	assign rb_n_oe = !idle;

	////////////////////////////////////////////////////////////////////
	// Output data held for the link side

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_data  <= 40'h0000000000;
			out_len   <= 3'h0;
			out_valid <= 1'b0;
			out_dup   <= 1'b0;
		end else if (do_reset || accept) begin
			out_valid <= 1'b0;
		end else if (id_addr) begin
			out_valid <= 1'b1;
			out_dup   <= 1'b1;
			if (ev_byte == nidfc_pkg::ID_ADDR_CODE) begin
				out_data <= ID_CODE;
				out_len  <= nidfc_pkg::ID_BYTES;
			end else if (ev_byte == nidfc_pkg::ID_ADDR_SIG) begin
				out_data <= {8'h00, SIG_CODE};
				out_len  <= nidfc_pkg::SIG_BYTES;
			end else begin
				out_len  <= 3'h0;
			end
		end else if (gf_pend && (busy_cnt == 16'h0001)) begin
			// P1 first, P2 to P4 zero
			out_data  <= {32'h00000000, feat_rd};
			out_len   <= nidfc_pkg::PARAM_BYTES;
			out_valid <= 1'b1;
			out_dup   <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_mode <= 1'b0;
		end else if (is_status) begin
			stat_mode <= 1'b1;
		end else if (is_rmode || accept || do_reset) begin
			stat_mode <= 1'b0;
		end
	end

	// Registered so the link side never samples a mux in transition
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pres_data  <= 40'h0000000000;
			pres_len   <= 3'h0;
			pres_valid <= 1'b0;
			pres_dup   <= 1'b0;
		end else begin
			pres_data  <= stat_mode ? {32'h00000000, stat_byte} : out_data;
			pres_len   <= stat_mode ? nidfc_pkg::STAT_BYTES : out_len;
			pres_valid <= stat_mode || out_valid;
			pres_dup   <= stat_mode || out_dup;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link side: pin sampling

	logic [13:0] pin_s;
	logic [13:0] pin_q;
	logic [2:0]  ctl_s;
	logic [2:0]  idx;

	nidfc_sync2 #(
		.W (14)
	) u_pin_sync (
		.clk (link_clk),
		.rst (rst),
		.d   ({ce_n, cle, ale, we_n, re_n, dqs_i, dq_i}),
		.q   (pin_s)
	);

	nidfc_sync2 #(
		.W (3)
	) u_ctl_sync (
		.clk (link_clk),
		.rst (rst),
		.d   ({pres_valid, pres_dup, sync_on}),
		.q   (ctl_s)
	);

	wire       l_ce    = !pin_s[13];
	wire       l_cle   = pin_s[12];
	wire       l_ale   = pin_s[11];
	wire       l_we_up = pin_s[10] && !pin_q[10];
	wire       l_wr    = pin_s[9];
	wire       l_re_up = pin_s[9] && !pin_q[9];
	wire       l_dqs_up = pin_s[8] && !pin_q[8];
	wire       l_cle_up = pin_s[12] && !pin_q[12];
	wire       l_ale_up = pin_s[11] && !pin_q[11];
	wire [7:0] l_dq    = pin_s[7:0];
	wire       l_valid = ctl_s[2];
	wire       l_dup   = ctl_s[1];
	wire       l_sync  = ctl_s[0];

	// Asynchronous bus: every write strobe rise is one cycle
	wire a_ev   = l_ce && !l_sync && l_we_up;
	// Synchronous bus: latch on enable rise, data on DQS rise
	wire s_cmd  = l_ce && l_sync && l_wr && l_cle_up && !l_ale;
	wire s_addr = l_ce && l_sync && l_wr && l_ale_up && !l_cle;
	wire s_din  = l_ce && l_sync && l_wr && l_cle && l_ale && l_dqs_up;

	wire [1:0] l_kind = (l_cle && !l_ale) || s_cmd ? nidfc_pkg::EV_CMD :
	                    (l_ale && !l_cle) || s_addr ? nidfc_pkg::EV_ADDR :
	                    nidfc_pkg::EV_DIN;
	wire       l_ev   = a_ev || s_cmd || s_addr || s_din;
	wire       l_ca   = l_ev && (l_kind != nidfc_pkg::EV_DIN);

	nidfc_xfer u_ev_xfer (
		.src_clk   (link_clk),
		.dst_clk   (ref_clk),
		.rst       (rst),
		.send      (l_ev),
		.src_word  ({l_kind, l_dq}),
		.src_busy  (),
		.dst_pulse (ev_pulse),
		.dst_word  (ev_word)
	);

	////////////////////////////////////////////////////////////////////
	// Link side: data output

	wire       a_win  = l_ce && !l_sync && !pin_s[9];
	wire       s_win  = l_ce && l_sync && !l_wr && l_cle && l_ale;
	// Data words are quiet while the synced valid level is low
	wire [63:0] l_bytes = {24'h000000, pres_data};
	wire [7:0]  l_sel   = l_bytes[{idx, 3'b000} +: 8];
	wire        l_have  = l_valid && (idx < pres_len);
	// Status byte repeats on every strobe so polling sees ready
	wire        l_stat  = (pres_len == nidfc_pkg::STAT_BYTES);
	wire        s_adv   = s_win && (dqs_o || !l_dup);
	wire        a_adv   = l_ce && !l_sync && l_re_up;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			pin_q <= 14'h0000;
		end else begin
			pin_q <= pin_s;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			idx <= 3'h0;
		end else if (l_ca) begin
			idx <= 3'h0;
		end else if ((a_adv || s_adv) && l_have && !l_stat) begin
			idx <= idx + 3'h1;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			dq_o   <= 8'h00;
			dq_oe  <= 1'b0;
			dqs_o  <= 1'b0;
			dqs_oe <= 1'b0;
		end else begin
			dq_o   <= l_have ? l_sel : 8'h00;
			dq_oe  <= a_win || s_win;
			dqs_o  <= s_win ? !dqs_o : 1'b0;
			dqs_oe <= s_win;
		end
	end

endmodule : nidfc_top

// *** test/nidfc_assertions.sv ***
/*
 * Port checker for nidfc_top: busy timing, pin drive and read strobes.
 * Assumes a host that keeps re_n high while it writes.
 */
module nidfc_assertions (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       link_clk,
	input wire logic       ce_n,
	input wire logic       cle,
	input wire logic       ale,
	input wire logic       we_n,
	input wire logic       re_n,
	input wire logic [7:0] dq_i,
	input wire logic [7:0] dq_o,
	input wire logic       dq_oe,
	input wire logic       dqs_i,
	input wire logic       dqs_o,
	input wire logic       dqs_oe,
	input wire logic       rb_n_o,
	input wire logic       rb_n_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BUSY_CYC = nidfc_pkg::FEAT_CYC;
	int busy_cnt;

	// Length of the current busy stretch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) busy_cnt <= 0;
		else if (rb_n_oe) busy_cnt <= busy_cnt + 1;
		else busy_cnt <= 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_busy_start;
		$rose(rb_n_oe);
	endsequence
	sequence s_read_held;
		(!re_n && dq_oe && !ale)[*3];
	endsequence

	a_rb_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
		rb_n_oe |-> rb_n_o == 1'b0) else $error("ready line not pulled low");
	a_busy_min_hold: assert property (@(posedge ref_clk) disable iff (rst)
		s_busy_start |=> rb_n_oe[*8]) else $error("busy dropped early");
	a_busy_exact_len: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(rb_n_oe) |-> busy_cnt == BUSY_CYC) else $error("busy length wrong");
	a_busy_bound: assert property (@(posedge ref_clk) disable iff (rst)
		rb_n_oe |-> busy_cnt < BUSY_CYC) else $error("busy too long");
	a_dq_release: assert property (@(posedge link_clk) disable iff (rst)
		ce_n[*4] |-> !dq_oe) else $error("data driven while deselected");
	a_write_no_drive: assert property (@(posedge link_clk) disable iff (rst)
		(re_n && !we_n)[*2] |-> !dq_oe) else $error("data driven during write");
	a_dq_hold_byte: assert property (@(posedge link_clk) disable iff (rst)
		s_read_held |-> $stable(dq_o)) else $error("byte changed without strobe");
	a_dqs_write_side: assert property (@(posedge link_clk) disable iff (rst)
		re_n[*4] |-> !dqs_oe) else $error("strobe driven on write side");
	a_dqs_toggle: assert property (@(posedge link_clk) disable iff (rst)
		dqs_oe && $past(dqs_oe) |-> dqs_o != $past(dqs_o)) else $error("strobe did not toggle");
endmodule : nidfc_assertions

// *** test/nidfc_host.sv ***
/*
 * Behavioural host controller: asynchronous bus cycles and DDR commands.
 * Assumes the bench calls its tasks one at a time.
 */
module nidfc_host (
	input  wire logic       link_clk,
	input  wire logic [7:0] dq_o,
	output logic            ce_n,
	output logic            cle,
	output logic            ale,
	output logic            we_n,
	output logic            re_n,
	output logic      [7:0] dq_i,
	output logic            dqs_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{ce_n, we_n, re_n} = 3'h7;
		{cle, ale, dqs_i} = 3'h0;
		dq_i = 8'h5a;
	end

	// Strobe held, cycles spaced, no enhanced status
	task automatic wcyc(input logic [1:0] kind, input logic [7:0] b);
		@(posedge link_clk);
		ce_n <= 1'b0;
		cle  <= (kind == nidfc_pkg::EV_CMD);
		ale  <= (kind == nidfc_pkg::EV_ADDR);
		dq_i <= b;
		we_n <= 1'b0;
		repeat (2) @(posedge link_clk);
		we_n <= 1'b1;
		repeat (2) @(posedge link_clk);
		cle  <= 1'b0;
		ale  <= 1'b0;
		// Released bus shows the inverse, never the stale byte
		dq_i <= ~b;
	endtask : wcyc

	task automatic rbyte(output logic [7:0] b);
		@(posedge link_clk);
		ce_n <= 1'b0;
		re_n <= 1'b0;
		repeat (6) @(posedge link_clk);
		b = dq_o;
		re_n <= 1'b1;
		repeat (3) @(posedge link_clk);
	endtask : rbyte

	// DDR command or address: enable pulse with write direction
	task automatic ddr_cmd(input bit adr, input logic [7:0] b);
		@(posedge link_clk);
		re_n <= 1'b1;
		dq_i <= b;
		cle  <= !adr;
		ale  <= adr;
		repeat (3) @(posedge link_clk);
		cle  <= 1'b0;
		ale  <= 1'b0;
		dq_i <= ~b;
	endtask : ddr_cmd

	// DDR read window, data taken mid-cycle
	task automatic ddr_rd(output logic [7:0] b [6]);
		@(posedge link_clk);
		cle  <= 1'b1;
		ale  <= 1'b1;
		re_n <= 1'b0;
		repeat (3) @(posedge link_clk);
		for (int i = 0; i < 6; i++) begin
			@(negedge link_clk);
			b[i] = dq_o;
		end
		@(posedge link_clk);
		re_n <= 1'b1;
		cle  <= 1'b0;
		ale  <= 1'b0;
	endtask : ddr_rd

	task automatic idle;
		@(posedge link_clk);
		ce_n <= 1'b1;
		repeat (5) @(posedge link_clk);
	endtask : idle
endmodule : nidfc_host

// *** test/tb_nidfc_top.sv ***
/*
 * Self-checking bench for nidfc_top with the host model on its pins.
 * Assumes package busy times of FEAT_CYC reference cycles.
 */
module tb_nidfc_top;
	timeunit 1ns;
	timeprecision 100ps;
	// Arbitrary identification values
	localparam logic [39:0] ID_VAL  = 40'h5a4b3c2d1e;
	localparam logic [31:0] SIG_VAL = 32'h13243546;
	localparam logic [7:0] FA [7]  = '{8'h01, 8'h10, 8'h80, 8'h81, 8'h90, 8'h02, 8'hff};
	localparam logic [7:0] DEF [7] = '{nidfc_pkg::TIMING_RST, nidfc_pkg::DRIVE_RST,
		nidfc_pkg::DRIVE_RST, nidfc_pkg::RB_RST, nidfc_pkg::ARRAY_RST, 8'h00, 8'h00};
	localparam logic [7:0] MSK [7] = '{nidfc_pkg::TIMING_MASK, nidfc_pkg::DRIVE_MASK,
		nidfc_pkg::DRIVE_MASK, nidfc_pkg::RB_MASK, nidfc_pkg::ARRAY_MASK, 8'h00, 8'h00};
	logic       ref_clk, rst, link_clk, ce_n, cle, ale, we_n, re_n, dqs_i;
	logic       dq_oe, dqs_o, dqs_oe, rb_n_o, rb_n_oe;
	logic [7:0] dq_i, dq_o;
	int         bad_count = 0;
	int         cmp_count = 0;

	nidfc_top #(.ID_CODE(ID_VAL), .SIG_CODE(SIG_VAL)) u_nidfc_top (
		.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .re_n(re_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
		.dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .rb_n_o(rb_n_o), .rb_n_oe(rb_n_oe));
	nidfc_host u_nidfc_host (.link_clk(link_clk), .dq_o(dq_o), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .re_n(re_n), .dq_i(dq_i), .dqs_i(dqs_i));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #24 link_clk = ~link_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Host waits for idle before the next command
	task automatic wait_ready(input bit need);
		int n;
		n = 0;
		while (rb_n_oe !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 100 && need) begin
			bad_count++;
			$display("Error at %0t: busy never started", $time);
			report_and_stop();
		end
		n = 0;
		while (rb_n_oe !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 400) begin
			bad_count++;
			$display("Error at %0t: busy never ended", $time);
			report_and_stop();
		end
		repeat (3) @(posedge link_clk);
	endtask : wait_ready

	task automatic send_wr(input logic [7:0] fa, input logic [7:0] p1);
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_SET_FEAT);
		u_nidfc_host.wcyc(nidfc_pkg::EV_ADDR, fa);
		u_nidfc_host.wcyc(nidfc_pkg::EV_DIN, p1);
		for (int i = 0; i < 3; i++) u_nidfc_host.wcyc(nidfc_pkg::EV_DIN, 8'h00);
	endtask : send_wr

	task automatic feat_rd(input logic [7:0] fa, input logic [7:0] exp, input bit need);
		logic [7:0] b;
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_GET_FEAT);
		u_nidfc_host.wcyc(nidfc_pkg::EV_ADDR, fa);
		wait_ready(need);
		for (int i = 0; i < 4; i++) begin
			u_nidfc_host.rbyte(b);
			chk(b, (i == 0) ? exp : 8'h00);
		end
		u_nidfc_host.idle();
	endtask : feat_rd

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_read_id;
		logic [7:0]  b;
		logic [39:0] code;
		for (int k = 0; k < 2; k++) begin
			code = (k == 0) ? ID_VAL : {8'h00, SIG_VAL};
			u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_READ_ID);
			u_nidfc_host.wcyc(nidfc_pkg::EV_ADDR, (k == 0) ? 8'h00 : 8'h20);
			repeat (3) @(posedge link_clk);
			for (int i = 0; i < 6; i++) begin
				u_nidfc_host.rbyte(b);
				chk(b, (i < 5) ? code[8*i +: 8] : 8'h00);
			end
			u_nidfc_host.idle();
		end
	endtask : t_read_id

	task automatic t_features;
		for (int i = 0; i < 7; i++) begin
			feat_rd(FA[i], DEF[i], i < 5);
			send_wr(FA[i], (i == 0) ? 8'hc3 : 8'hff);
			wait_ready(i < 5);
			feat_rd(FA[i], ((i == 0) ? 8'hc3 : 8'hff) & MSK[i], i < 5);
		end
	endtask : t_features

	task automatic t_status;
		logic [7:0] b;
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_GET_FEAT);
		u_nidfc_host.wcyc(nidfc_pkg::EV_ADDR, nidfc_pkg::FA_RB_PULL);
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_STATUS);
		u_nidfc_host.rbyte(b);
		chk(b, 8'h00);
		wait_ready(0);
		u_nidfc_host.rbyte(b);
		chk(b, nidfc_pkg::STAT_READY);
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_READ_MODE);
		u_nidfc_host.rbyte(b);
		chk(b, nidfc_pkg::RB_MASK);
		u_nidfc_host.idle();
	endtask : t_status

	task automatic t_reset;
		logic [7:0] d [6];
		send_wr(nidfc_pkg::FA_TIMING, 8'h25);
		wait_ready(0);
		feat_rd(nidfc_pkg::FA_TIMING, 8'h03, 1);
		send_wr(nidfc_pkg::FA_ARRAY, 8'h01);
		wait_ready(1);
		u_nidfc_host.wcyc(nidfc_pkg::EV_CMD, nidfc_pkg::CMD_RESET);
		wait_ready(0);
		feat_rd(nidfc_pkg::FA_DRIVE, nidfc_pkg::DRIVE_MASK, 1);
		feat_rd(nidfc_pkg::FA_TIMING, 8'h03, 1);
		feat_rd(nidfc_pkg::FA_ARRAY, nidfc_pkg::ARRAY_RST, 1);
		send_wr(nidfc_pkg::FA_TIMING, 8'h14);
		wait_ready(1);
		u_nidfc_host.ddr_cmd(1'b0, nidfc_pkg::CMD_READ_ID);
		u_nidfc_host.ddr_cmd(1'b1, nidfc_pkg::ID_ADDR_CODE);
		u_nidfc_host.ddr_rd(d);
		for (int i = 0; i < 6; i++) chk(d[i], ID_VAL[8*(i/2) +: 8]);
		u_nidfc_host.ddr_cmd(1'b0, nidfc_pkg::CMD_RESET);
		wait_ready(0);
		feat_rd(nidfc_pkg::FA_TIMING, nidfc_pkg::TIMING_RST, 1);
	endtask : t_reset

	initial begin
		rst = 1'b1;
		repeat (4) @(posedge ref_clk);
		repeat (2) @(posedge link_clk);
		@(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge link_clk);
		t_read_id();
		t_features();
		t_status();
		t_reset();
		report_and_stop();
	end
endmodule : tb_nidfc_top

bind nidfc_top nidfc_assertions u_nidfc_assertions (
	.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .ce_n(ce_n), .cle(cle), .ale(ale),
	.we_n(we_n), .re_n(re_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
	.dqs_o(dqs_o), .dqs_oe(dqs_oe), .rb_n_o(rb_n_o), .rb_n_oe(rb_n_oe));
